// ==== rtl/sgp_ports.sv ====
// Purpose: Pin logic, latches and direction registers of ports E, F, G.
// Assumes: Pins arrive asynchronously; peripherals run on this clock.
// Notes: Pin drive is registered, so it follows a write by one cycle.
`timescale 1ns/10ps
module sgp_ports
  import sgp_pkg::*;
#(
  parameter int unsigned ADDR_BITS = ADDR_WIDTH
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Register port.
  input wire logic [ADDR_BITS-1:0] address,
  input wire logic [DATA_WIDTH-1:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [DATA_WIDTH-1:0] readData,
  // Peripheral enables.
  input wire logic serialPeriphEnable,
  input wire logic serialPeriphMasterSelect,
  input wire logic asyncSerialEnable,
  input wire logic [2*TA_CHANNELS-1:0] timerAEdgeLevelSelect,
  input wire logic [2*TB_CHANNELS-1:0] timerBEdgeLevelSelect,
  input wire logic [G_WIDTH-1:0] keypadIrqEnable,
  // Peripheral drive for claimed pins.
  input wire logic [E_WIDTH-1:0] periphEOut,
  input wire logic [E_WIDTH-1:0] periphEOutEnable,
  input wire logic [F_WIDTH-1:0] periphFOut,
  input wire logic [F_WIDTH-1:0] periphFOutEnable,
  // Synchronised pin levels for the peripherals.
  output logic [E_WIDTH-1:0] pinESampled,
  output logic [F_WIDTH-1:0] pinFSampled,
  output logic [G_WIDTH-1:0] keypadInput,
  // Port E pins.
  input wire logic [E_WIDTH-1:0] pinEIn,
  output logic [E_WIDTH-1:0] pinEOut,
  output logic [E_WIDTH-1:0] pinEOutEnable,
  // Port F pins.
  input wire logic [F_WIDTH-1:0] pinFIn,
  output logic [F_WIDTH-1:0] pinFOut,
  output logic [F_WIDTH-1:0] pinFOutEnable,
  // Port G pins.
  input wire logic [G_WIDTH-1:0] pinGIn,
  output logic [G_WIDTH-1:0] pinGOut,
  output logic [G_WIDTH-1:0] pinGOutEnable
);

  // Three low address bits already keep every register offset apart once
  // the offsets are cut to ADDR_BITS bits; the check below asks for four.
  if (ADDR_BITS < 4) begin : gen_bad_addr
    $error("sgp_ports: ADDR_BITS too small for the register map.");
  end
  // The field slices below are written for byte data and these widths.
  if (DATA_WIDTH != 8) begin : gen_bad_data
    $error("sgp_ports: DATA_WIDTH must be 8.");
  end
  if (E_WIDTH != 8 || F_WIDTH != 7 || G_WIDTH != 3) begin : gen_bad_ports
    $error("sgp_ports: port widths do not match the pin logic.");
  end
  // Port F carries four timer A pins with the timer B pins above them.
  if (F_TA_FIRST_CHANNEL + F_TA_PINS > TA_CHANNELS) begin : gen_bad_ta
    $error("sgp_ports: port F timer A pins exceed the timer A channels.");
  end
  if (F_TB_FIRST_BIT + TB_CHANNELS > F_WIDTH) begin : gen_bad_tb
    $error("sgp_ports: port F timer B pins exceed the port width.");
  end

  sgp_state_t s_q;
  sgp_state_t s_d;
  logic [E_WIDTH-1:0] claimE;
  logic [F_WIDTH-1:0] claimF;

  // A timer channel owns its pin when either edge/level select bit is set.
  function automatic logic channelActive(input logic [1:0] edgeLevelSelect);
    channelActive = |edgeLevelSelect;
  endfunction : channelActive

  // A read returns the latch for output bits and the pin for input bits.
  function automatic logic [7:0] mixRead(input logic [7:0] latch,
                                         input logic [7:0] dir,
                                         input logic [7:0] pin);
    mixRead = (latch & dir) | (pin & ~dir);
  endfunction : mixRead

  // Register selected by an address; SEL_NONE covers every unmapped one.
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_E_LATCH,
    SEL_F_LATCH,
    SEL_G_LATCH,
    SEL_E_DIRECTION,
    SEL_F_DIRECTION,
    SEL_G_DIRECTION
  } sgp_reg_sel_t;

  // Offsets are cut or widened to the bus width, so a narrow bus still
  // decodes without reaching past its top bit.
  function automatic sgp_reg_sel_t regSelect(
      input logic [ADDR_BITS-1:0] regAddress);
    unique case (regAddress)
      ADDR_BITS'(ADDR_PORT_E_LATCH): regSelect = SEL_E_LATCH;
      ADDR_BITS'(ADDR_PORT_F_LATCH): regSelect = SEL_F_LATCH;
      ADDR_BITS'(ADDR_PORT_G_LATCH): regSelect = SEL_G_LATCH;
      ADDR_BITS'(ADDR_PORT_E_DIRECTION): regSelect = SEL_E_DIRECTION;
      ADDR_BITS'(ADDR_PORT_F_DIRECTION): regSelect = SEL_F_DIRECTION;
      ADDR_BITS'(ADDR_PORT_G_DIRECTION): regSelect = SEL_G_DIRECTION;
      default: regSelect = SEL_NONE;
    endcase
  endfunction : regSelect

  always_comb begin
    claimE = '0;
    claimE[BIT_E_SPI_CLOCK] = serialPeriphEnable;
    claimE[BIT_E_SPI_MOSI] = serialPeriphEnable;
    claimE[BIT_E_SPI_MISO] = serialPeriphEnable;
    claimE[BIT_E_SPI_SELECT] = serialPeriphEnable
                               & ~serialPeriphMasterSelect;
    claimE[BIT_E_TA_CH1] = channelActive(timerAEdgeLevelSelect[3:2]);
    claimE[BIT_E_TA_CH0] = channelActive(timerAEdgeLevelSelect[1:0]);
    claimE[BIT_E_SCI_RX] = asyncSerialEnable;
    claimE[BIT_E_SCI_TX] = asyncSerialEnable;
    claimF = '0;
    for (int i = 0; i < F_TA_PINS; i++) begin
      claimF[i] = channelActive(
        timerAEdgeLevelSelect[2*(i+F_TA_FIRST_CHANNEL) +: 2]);
    end
    for (int i = 0; i < TB_CHANNELS; i++) begin
      claimF[F_TB_FIRST_BIT+i] =
        channelActive(timerBEdgeLevelSelect[2*i +: 2]);
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.eSync1 = pinEIn;
    s_d.eSync2 = s_q.eSync1;
    s_d.fSync1 = pinFIn;
    s_d.fSync2 = s_q.fSync1;
    s_d.gSync1 = pinGIn;
    s_d.gSync2 = s_q.gSync1;

    // Latches load on every write, whatever the direction bits hold.
    if (writeStrobe) begin
      unique case (regSelect(address))
        SEL_E_LATCH: s_d.eLatch = writeData;
        SEL_F_LATCH: s_d.fLatch = writeData[6:0];
        SEL_G_LATCH: s_d.gLatch = writeData[2:0];
        SEL_E_DIRECTION: s_d.eDir = writeData;
        SEL_F_DIRECTION: s_d.fDir = writeData[6:0];
        SEL_G_DIRECTION: s_d.gDir = writeData[2:0];
        default: ;
      endcase
    end

    // Direction picks latch or pin even on claimed pins.
    s_d.rdData = READ_UNMAPPED;
    if (readStrobe) begin
      unique case (regSelect(address))
        SEL_E_LATCH:
          s_d.rdData = mixRead(s_q.eLatch, s_q.eDir, s_q.eSync2);
        SEL_F_LATCH:
          s_d.rdData = mixRead({1'b0, s_q.fLatch}, {1'b0, s_q.fDir},
                               {1'b0, s_q.fSync2});
        SEL_G_LATCH:
          s_d.rdData = mixRead({5'h00, s_q.gLatch}, {5'h00, s_q.gDir},
                               {5'h00, s_q.gSync2});
        SEL_E_DIRECTION: s_d.rdData = s_q.eDir;
        SEL_F_DIRECTION: s_d.rdData = {1'b0, s_q.fDir};
        SEL_G_DIRECTION: s_d.rdData = {5'h00, s_q.gDir};
        default: s_d.rdData = READ_UNMAPPED;
      endcase
    end

    // Pin drive uses the values settled at this edge, so a direction
    // change and the latch write before it never overlap on the pin.
    s_d.eOut = (claimE & periphEOut) | (~claimE & s_q.eLatch);
    s_d.eOe = (claimE & periphEOutEnable)
              | (~claimE & s_q.eDir);
    // A claimed slave select is an input whatever the SPI offers.
    if (claimE[BIT_E_SPI_SELECT]) begin
      s_d.eOe[BIT_E_SPI_SELECT] = 1'b0;
    end
    s_d.fOut = (claimF & periphFOut) | (~claimF & s_q.fLatch);
    s_d.fOe = (claimF & periphFOutEnable)
              | (~claimF & s_q.fDir);
    s_d.gOut = s_q.gLatch;
    // A keypad pin is held as an input so it cannot fight the key.
    s_d.gOe = s_q.gDir & ~keypadIrqEnable;
  end

  // Latches are left out of reset on purpose, so they keep their data.
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q.eDir <= RESET_E_DIRECTION;
      s_q.fDir <= RESET_F_DIRECTION;
      s_q.gDir <= RESET_G_DIRECTION;
      s_q.eSync1 <= '0;
      s_q.eSync2 <= '0;
      s_q.fSync1 <= '0;
      s_q.fSync2 <= '0;
      s_q.gSync1 <= '0;
      s_q.gSync2 <= '0;
      s_q.eOut <= '0;
      s_q.eOe <= '0;
      s_q.fOut <= '0;
      s_q.fOe <= '0;
      s_q.gOut <= '0;
      s_q.gOe <= '0;
      s_q.rdData <= READ_UNMAPPED;
    end else begin
      s_q <= s_d;
    end
  end

  assign readData = s_q.rdData;
  assign pinESampled = s_q.eSync2;
  assign pinFSampled = s_q.fSync2;
  assign keypadInput = s_q.gSync2;
  assign pinEOut = s_q.eOut;
  assign pinEOutEnable = s_q.eOe;
  assign pinFOut = s_q.fOut;
  assign pinFOutEnable = s_q.fOe;
  assign pinGOut = s_q.gOut;
  assign pinGOutEnable = s_q.gOe;

endmodule : sgp_ports

// ==== rtl/sgp_pkg.sv ====
// Purpose: Shared constants for the port E, F and G pin logic.
// Assumes: Byte-wide register port with a one-cycle read latency.
// Notes: Direction register offsets are local to this block.
package sgp_pkg;
  localparam int unsigned E_WIDTH = 8;
  localparam int unsigned F_WIDTH = 7;
  localparam int unsigned G_WIDTH = 3;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 8;
  // Number of timer channels that can claim port pins.
  localparam int unsigned TA_CHANNELS = 6;
  localparam int unsigned TB_CHANNELS = 2;

  localparam logic [7:0] ADDR_PORT_E_LATCH = 8'h08;
  localparam logic [7:0] ADDR_PORT_F_LATCH = 8'h09;
  localparam logic [7:0] ADDR_PORT_G_LATCH = 8'h0A;
  localparam logic [7:0] ADDR_PORT_E_DIRECTION = 8'h0C;
  localparam logic [7:0] ADDR_PORT_F_DIRECTION = 8'h0D;
  localparam logic [7:0] ADDR_PORT_G_DIRECTION = 8'h0E;

  localparam logic [7:0] RESET_E_DIRECTION = 8'h00;
  localparam logic [6:0] RESET_F_DIRECTION = 7'h00;
  localparam logic [2:0] RESET_G_DIRECTION = 3'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Port E bit positions of the borrowed functions.
  localparam int unsigned BIT_E_SPI_CLOCK = 7;
  localparam int unsigned BIT_E_SPI_MOSI = 6;
  localparam int unsigned BIT_E_SPI_MISO = 5;
  localparam int unsigned BIT_E_SPI_SELECT = 4;
  localparam int unsigned BIT_E_TA_CH1 = 3;
  localparam int unsigned BIT_E_TA_CH0 = 2;
  localparam int unsigned BIT_E_SCI_RX = 1;
  localparam int unsigned BIT_E_SCI_TX = 0;
  // Port F: bits 3..0 carry timer A channels 5..2, bits 5..4 timer B 1..0.
  localparam int unsigned F_TA_FIRST_CHANNEL = 2;
  localparam int unsigned F_TA_PINS = 4;
  localparam int unsigned F_TB_FIRST_BIT = 4;

  typedef struct packed {
    logic [7:0] eLatch;
    logic [6:0] fLatch;
    logic [2:0] gLatch;
    logic [7:0] eDir;
    logic [6:0] fDir;
    logic [2:0] gDir;
    logic [7:0] eSync1;
    logic [7:0] eSync2;
    logic [6:0] fSync1;
    logic [6:0] fSync2;
    logic [2:0] gSync1;
    logic [2:0] gSync2;
    logic [7:0] eOut;
    logic [7:0] eOe;
    logic [6:0] fOut;
    logic [6:0] fOe;
    logic [2:0] gOut;
    logic [2:0] gOe;
    logic [7:0] rdData;
  } sgp_state_t;
endpackage : sgp_pkg

// ==== tb/sgp_ports_sva.sv ====
// Purpose: Port-level assertions for the E, F and G pin logic.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Claimed-pin drive is checked one edge after its cause.
`timescale 1ns/10ps
module sgp_ports_sva
  import sgp_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset,
  // Peripheral controls.
  input wire logic serialPeriphEnable,
  input wire logic serialPeriphMasterSelect,
  input wire logic asyncSerialEnable,
  input wire logic [11:0] timerAEdgeLevelSelect,
  input wire logic [3:0] timerBEdgeLevelSelect,
  input wire logic [2:0] keypadIrqEnable,
  input wire logic [7:0] periphEOut,
  input wire logic [7:0] periphEOutEnable,
  input wire logic [6:0] periphFOutEnable,
  // Pins.
  input wire logic [7:0] pinEIn,
  input wire logic [7:0] pinESampled,
  input wire logic [7:0] pinEOut,
  input wire logic [7:0] pinEOutEnable,
  input wire logic [6:0] pinFOutEnable,
  input wire logic [2:0] pinGOutEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_dir_reset_clear: assert property ($fell(reset) |->
    pinEOutEnable == 8'h00 && pinFOutEnable == 7'h00)
    else $error("pin drive left on after reset");
  a_sync_two_edges: assert property (!$past(reset) &&
    !$past(reset, 2) |-> pinESampled == $past(pinEIn, 2))
    else $error("pin sample latency wrong");
  a_spi_clock_drive: assert property (serialPeriphEnable |=>
    pinEOut[7] == $past(periphEOut[7]) &&
    pinEOutEnable[7] == $past(periphEOutEnable[7]))
    else $error("spi clock pin not driven by peripheral");
  a_spi_data_pins: assert property (serialPeriphEnable |=>
    pinEOutEnable[6:5] == $past(periphEOutEnable[6:5]))
    else $error("spi data pins not handed over");
  a_select_stays_input: assert property (serialPeriphEnable &&
    !serialPeriphMasterSelect |=> !pinEOutEnable[4])
    else $error("slave select pin driven");
  a_sci_pins_claim: assert property (asyncSerialEnable |=>
    pinEOutEnable[1:0] == $past(periphEOutEnable[1:0]))
    else $error("sci pins not handed over");
  a_timer_a_claim: assert property (timerAEdgeLevelSelect[1:0] != 2'h0
    |=> pinEOutEnable[2] == $past(periphEOutEnable[2]))
    else $error("timer a pin not handed over");
  a_timer_b_claim: assert property (timerBEdgeLevelSelect[3:2] != 2'h0
    |=> pinFOutEnable[5] == $past(periphFOutEnable[5]))
    else $error("timer b pin not handed over");
  a_keypad_forces_input: assert property (keypadIrqEnable != 3'h0
    |=> (pinGOutEnable & $past(keypadIrqEnable)) == 3'h0)
    else $error("keypad pin driven");
endmodule : sgp_ports_sva
bind sgp_ports sgp_ports_sva sva_u (.*);

// ==== tb/sgp_pins_model.sv ====
// Purpose: Far side of the pins: board devices that always drive.
// Assumes: Where the block drives, it wins over the board device.
// Notes: No pin ever floats, so no unknown reaches the synchroniser.
`timescale 1ns/10ps
module sgp_pins_model (
  // Block drive.
  input wire logic [7:0] pinEOut,
  input wire logic [7:0] pinEOutEnable,
  input wire logic [6:0] pinFOut,
  input wire logic [6:0] pinFOutEnable,
  input wire logic [2:0] pinGOut,
  input wire logic [2:0] pinGOutEnable,
  // Board device levels.
  input wire logic [7:0] extE,
  input wire logic [6:0] extF,
  input wire logic [2:0] extG,
  // Resolved wires.
  output logic [7:0] pinEIn,
  output logic [6:0] pinFIn,
  output logic [2:0] pinGIn
);
  assign pinEIn = (pinEOut & pinEOutEnable) | (extE & ~pinEOutEnable);
  assign pinFIn = (pinFOut & pinFOutEnable) | (extF & ~pinFOutEnable);
  assign pinGIn = (pinGOut & pinGOutEnable) | (extG & ~pinGOutEnable);
endmodule : sgp_pins_model

// ==== tb/shared_gpio_ports_e_f_g_test.sv ====
// Purpose: Self-checking bench for the port E, F and G pin logic.
// Assumes: Register reads answer in the cycle after the strobe.
// Notes: Board devices drive E=A5, F=55, G=5 wherever the block is off.
`timescale 1ns/10ps
module shared_gpio_ports_e_f_g_test;
  import sgp_pkg::*;
  logic clock = 1'b0, reset = 1'b1, writeStrobe = 1'b0, readStrobe = 1'b0;
  logic serialPeriphEnable = 1'b0, serialPeriphMasterSelect = 1'b0;
  logic asyncSerialEnable = 1'b0;
  logic [11:0] timerAEdgeLevelSelect = 12'h000;
  logic [3:0] timerBEdgeLevelSelect = 4'h0;
  logic [7:0] address = 8'h00, writeData = 8'h00, readData, extE = 8'hA5;
  logic [7:0] periphEOut = 8'hFF, periphEOutEnable = 8'hB5;
  logic [7:0] pinEIn, pinEOut, pinEOutEnable, pinESampled;
  logic [6:0] periphFOut = 7'h7F, periphFOutEnable = 7'h2C, extF = 7'h55;
  logic [6:0] pinFIn, pinFOut, pinFOutEnable, pinFSampled;
  logic [2:0] keypadIrqEnable = 3'h0, extG = 3'h5, keypadInput;
  logic [2:0] pinGIn, pinGOut, pinGOutEnable;
  int errTotal = 0, nTests = 0, cycles = 0;
  sgp_ports dut_u (.*);
  sgp_pins_model model_u (.*);
  initial forever #4 clock = ~clock;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    @(negedge clock);
    check(readData, exp);
  endtask : rd
  task automatic settle;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask : settle
  task automatic t_reset_state;
    rd(8'h0C, 8'h00);
    rd(8'h0D, 8'h00);
    rd(8'h10, 8'h00);
    check(pinEOutEnable, 8'h00);
    $display("test reset state done");
  endtask : t_reset_state
  task automatic t_ports;
    wr(8'h08, 8'h3C);
    wr(8'h0C, 8'hF0);
    wr(8'h09, 8'h2A);
    wr(8'h0D, 8'h0F);
    wr(8'h0A, 8'h02);
    wr(8'h0E, 8'h03);
    settle();
    check(pinEOutEnable, 8'hF0);
    check(pinEOut & 8'hF0, 8'h30);
    check({1'b0, pinFOutEnable}, 8'h0F);
    check({1'b0, pinFOut}, 8'h2A);
    check({5'h00, pinGOut}, 8'h02);
    check({1'b0, pinFSampled}, 8'h5A);
    rd(8'h08, 8'h35);
    rd(8'h09, 8'h5A);
    rd(8'h0A, 8'h06);
    @(posedge clock);
    keypadIrqEnable <= 3'h1;
    settle();
    check({5'h00, pinGOutEnable}, 8'h02);
    check({5'h00, keypadInput}, 8'h07);
    rd(8'h0A, 8'h06);
    $display("test port data done");
  endtask : t_ports
  task automatic t_claims;
    @(posedge clock);
    serialPeriphEnable <= 1'b1;
    settle();
    check(pinEOutEnable, 8'hA0);
    check(pinEOut & 8'hE0, 8'hE0);
    check(pinESampled, 8'hA5);
    rd(8'h08, 8'h35);
    @(posedge clock);
    serialPeriphMasterSelect <= 1'b1;
    asyncSerialEnable <= 1'b1;
    timerAEdgeLevelSelect <= 12'h555;
    timerBEdgeLevelSelect <= 4'h5;
    settle();
    check(pinEOutEnable, 8'hB5);
    check({1'b0, pinFOutEnable}, 8'h2C);
    check({1'b0, pinFOut}, 8'h3F);
    check({1'b0, pinFSampled}, 8'h7D);
    @(posedge clock);
    serialPeriphEnable <= 1'b0;
    asyncSerialEnable <= 1'b0;
    timerAEdgeLevelSelect <= 12'h000;
    timerBEdgeLevelSelect <= 4'h0;
    settle();
    check(pinEOutEnable, 8'hF0);
    check({1'b0, pinFOutEnable}, 8'h0F);
    $display("test peripheral claims done");
  endtask : t_claims
  task automatic t_latch_keep;
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    settle();
    check(pinEOutEnable, 8'h00);
    wr(8'h0D, 8'h7F);
    rd(8'h09, 8'h2A);
    wr(8'h0E, 8'h07);
    rd(8'h0A, 8'h02);
    $display("test latch through reset done");
  endtask : t_latch_keep
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // A hang is cut short well past the seventy-odd cycles the tests need.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errTotal++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_reset_state();
    t_ports();
    t_claims();
    t_latch_keep();
    tally_and_finish();
  end
endmodule : shared_gpio_ports_e_f_g_test
